// [plesc_pkg.sv]
package plesc_pkg;
   // avalon word addresses are byte offsets here
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_SELECT  = 12'h620;
   localparam logic [11:0] OFF_FLAGS   = 12'h680;
   localparam logic [11:0] OFF_CONTROL = 12'h684;
   localparam logic [11:0] OFF_IRQ_EN  = 12'h690;
   localparam logic [11:0] OFF_EVCNT_A = 12'h694;
   localparam logic [11:0] OFF_EVCNT_B = 12'h698;
   localparam logic [11:0] OFF_FC_DEF  = 12'h69C;

   localparam int SEL_A_LSB = 0;
   localparam int SEL_B_LSB = 8;
   localparam int SEL_W     = 5;
   localparam logic [31:0] SELECT_MASK = 32'h00001F1F;

   localparam int F_RX_UR    = 0;
   localparam int F_MALFORM  = 2;
   localparam int F_NULL     = 3;
   localparam int F_OVERFLOW = 4;
   localparam int F_RX_TLP   = 16;
   localparam int F_RX_CFG   = 18;
   localparam int F_RX_MEM   = 19;
   localparam int F_RX_IO    = 20;
   localparam int F_EXT_MSG  = 21;
   localparam int F_RX_MSG   = 22;
   localparam logic [31:0] FLAGS_MASK = 32'h007D001D;

   localparam int C_FC_LSB = 0;
   localparam int C_FC_W   = 10;
   localparam int C_FC_OVR = 10;
   localparam int C_POSTED_TAG_SEQUENCING = 11;
   localparam logic [31:0] CONTROL_MASK = 32'h00000FFF;

   localparam logic [31:0] RESET_ZERO = 32'h00000000;
   localparam logic [9:0] FC_DEFAULT_INTERVAL = 10'h0FF;
   localparam logic [7:0] TAG_MAX_EXT   = 8'hFF;
   localparam logic [7:0] TAG_MAX_SHORT = 8'h1F;
   localparam int DL_EVENTS = 23;
   // code 0x10 is reserved, so bit 16 stays clear
   localparam logic [31:0] DL_VALID_CODES = 32'h007EF57F;
endpackage

// [plesc_regs.sv]
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
module plesc_regs
   import plesc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rstn,
   input  wire logic                   ce,
   input  wire logic [plesc_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   input  wire logic [3:0]             avs_byteenable,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   output logic                        avs_readdatavalid,
   input  wire logic [31:0]            tl_event,
   input  wire logic                   dl_event_valid,
   input  wire logic [4:0]             dl_event_code,
   input  wire logic                   posted_tlp_gen,
   input  wire logic                   ext_tag_en,
   output logic [7:0]                  posted_tag,
   output logic                        fc_update_pulse,
   output logic                        irq
);
   import plesc_pkg::*;

   typedef enum logic [1:0] {
      PLESC_IDLE = 2'b00,
      PLESC_ACK  = 2'b01
   } plesc_bus_t;

   plesc_bus_t  bus_q, bus_d;
   logic [31:0] sel_q, flags_q, ctrl_q, mask_q;
   logic [31:0] cnt_a_q, cnt_b_q;
   logic [31:0] rdata_q;
   logic [7:0]  tag_q;
   logic [9:0]  fc_cnt_q;
   logic        fc_pulse_q, irq_q, wait_q, rvalid_q;

   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] m);
      merge = ((old & ~be_mask(be)) | (wd & be_mask(be))) & m;
   endfunction

   // a request is taken one cycle after it appears, so waitrequest is one cycle long
   wire         req      = (avs_read | avs_write) & (bus_q == PLESC_IDLE);
   wire         take     = (bus_q == PLESC_ACK);
   wire         wr       = take & avs_write;
   wire         rd       = take & avs_read;
   wire         hit_sel  = (avs_address == OFF_SELECT);
   wire         hit_flg  = (avs_address == OFF_FLAGS);
   wire         hit_ctl  = (avs_address == OFF_CONTROL);
   wire         hit_msk  = (avs_address == OFF_IRQ_EN);
   wire [31:0]  w1c      = (wr & hit_flg) ? (avs_writedata & be_mask(avs_byteenable)) : '0;
   wire [31:0]  ev       = tl_event & FLAGS_MASK;
   wire [31:0]  flags_d  = ((flags_q & ~w1c) | ev) & FLAGS_MASK;
   wire [4:0]   sel_a    = sel_q[SEL_A_LSB +: SEL_W];
   wire [4:0]   sel_b    = sel_q[SEL_B_LSB +: SEL_W];
   wire         code_ok  = DL_VALID_CODES[dl_event_code];
   wire         hit_a    = dl_event_valid & code_ok & (dl_event_code == sel_a);
   wire         hit_b    = dl_event_valid & code_ok & (dl_event_code == sel_b);
   wire         fc_ovr   = ctrl_q[C_FC_OVR];
   wire [9:0]   fc_int   = fc_ovr ? ctrl_q[C_FC_LSB +: C_FC_W] : FC_DEFAULT_INTERVAL;
   wire         fc_done  = (fc_cnt_q >= fc_int);
   wire [7:0]   tag_max  = ext_tag_en ? TAG_MAX_EXT : TAG_MAX_SHORT;
   wire [7:0]   tag_d    = !ctrl_q[C_POSTED_TAG_SEQUENCING] ? 8'h00 :
                           (tag_q >= tag_max) ? 8'h00 : tag_q + 8'h01;
   wire [31:0]  rmux     = hit_sel ? sel_q :
                           hit_flg ? flags_q :
                           hit_ctl ? ctrl_q :
                           hit_msk ? mask_q :
                           (avs_address == OFF_EVCNT_A) ? cnt_a_q :
                           (avs_address == OFF_EVCNT_B) ? cnt_b_q :
                           (avs_address == OFF_FC_DEF) ? {22'h0, FC_DEFAULT_INTERVAL} :
                           32'h00000000;

   always_comb begin
      case (bus_q)
         PLESC_IDLE: bus_d = req ? PLESC_ACK : PLESC_IDLE;
         PLESC_ACK:  bus_d = PLESC_IDLE;
         default:    bus_d = PLESC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_q    <= PLESC_IDLE;
         wait_q   <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q  <= RESET_ZERO;
      end else if (ce) begin
         bus_q    <= bus_d;
         wait_q   <= ~req;
         rvalid_q <= rd;
         rdata_q  <= req & avs_read ? rmux : rdata_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_q   <= RESET_ZERO;
         ctrl_q  <= RESET_ZERO;
         mask_q  <= RESET_ZERO;
         flags_q <= RESET_ZERO;
      end else if (ce) begin
         if (wr & hit_sel) sel_q <= merge(sel_q, avs_writedata, avs_byteenable, SELECT_MASK);
         if (wr & hit_ctl) ctrl_q <= merge(ctrl_q, avs_writedata, avs_byteenable, CONTROL_MASK);
         if (wr & hit_msk) mask_q <= merge(mask_q, avs_writedata, avs_byteenable, FLAGS_MASK);
         flags_q <= flags_d;
      end
   end

   // saturating event counters on the selected link events
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_a_q <= RESET_ZERO;
         cnt_b_q <= RESET_ZERO;
      end else if (ce) begin
         if (hit_a && cnt_a_q != 32'hFFFFFFFF) cnt_a_q <= cnt_a_q + 32'h00000001;
         if (hit_b && cnt_b_q != 32'hFFFFFFFF) cnt_b_q <= cnt_b_q + 32'h00000001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tag_q      <= 8'h00;
         fc_cnt_q   <= 10'h000;
         fc_pulse_q <= 1'b0;
         irq_q      <= 1'b0;
      end else if (ce) begin
         if (posted_tlp_gen) tag_q <= tag_d;
         else if (!ctrl_q[C_POSTED_TAG_SEQUENCING]) tag_q <= 8'h00;
         fc_cnt_q   <= fc_done ? 10'h000 : fc_cnt_q + 10'h001;
         fc_pulse_q <= fc_done;
         irq_q      <= |(flags_d & mask_q);
      end
   end

   assign avs_readdata      = rdata_q;
   assign avs_waitrequest   = wait_q;
   assign avs_readdatavalid = rvalid_q;
   assign posted_tag        = tag_q;
   assign fc_update_pulse   = fc_pulse_q;
   assign irq               = irq_q;

   property p_flag_keep;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_RX_MSG] |=> flags_q[F_RX_MSG];
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("message flag lost");

   property p_w1c_clear;
      @(posedge clk) disable iff (!rstn)
         ce && w1c[F_RX_TLP] && !tl_event[F_RX_TLP] |=> !flags_q[F_RX_TLP];
   endproperty
   a_w1c_clear: assert property (p_w1c_clear) else $error("w1c did not clear");

   property p_flag_hold;
      @(posedge clk) disable iff (!rstn)
         ce && flags_q[F_OVERFLOW] && !w1c[F_OVERFLOW] |=> flags_q[F_OVERFLOW];
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

   property p_reserved_zero;
      @(posedge clk) disable iff (!rstn)
         ((flags_q & ~FLAGS_MASK) == 0) && ((ctrl_q & ~CONTROL_MASK) == 0)
         && ((sel_q & ~SELECT_MASK) == 0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_tag_zero;
      @(posedge clk) disable iff (!rstn)
         ce && !ctrl_q[C_POSTED_TAG_SEQUENCING] |=> posted_tag == 8'h00;
   endproperty
   a_tag_zero: assert property (p_tag_zero) else $error("tag not zero");

   property p_tag_inc;
      @(posedge clk) disable iff (!rstn)
         ce && posted_tlp_gen && ctrl_q[C_POSTED_TAG_SEQUENCING] && tag_q < tag_max
         |=> posted_tag == $past(tag_q) + 8'h01;
   endproperty
   a_tag_inc: assert property (p_tag_inc) else $error("tag not incremented");

   property p_tag_wrap;
      @(posedge clk) disable iff (!rstn)
         ce && posted_tlp_gen && ctrl_q[C_POSTED_TAG_SEQUENCING] && !ext_tag_en && tag_q == 8'h1F
         |=> posted_tag == 8'h00;
   endproperty
   a_tag_wrap: assert property (p_tag_wrap) else $error("short tag wrap");

   property p_fc_period;
      @(posedge clk) disable iff (!rstn)
         ce && fc_done && fc_ovr |=> fc_cnt_q == 10'h000;
   endproperty
   a_fc_period: assert property (p_fc_period) else $error("fc interval bad");

   property p_cnt_a;
      @(posedge clk) disable iff (!rstn)
         ce && hit_a && cnt_a_q < 32'hFFFFFFFF |=> cnt_a_q == $past(cnt_a_q) + 32'h00000001;
   endproperty
   a_cnt_a: assert property (p_cnt_a) else $error("counter a missed");

   property p_cnt_b_res;
      @(posedge clk) disable iff (!rstn)
         ce && dl_event_valid && !code_ok |=> cnt_b_q == $past(cnt_b_q);
   endproperty
   a_cnt_b_res: assert property (p_cnt_b_res) else $error("reserved code counted");

   property p_cnt_b;
      @(posedge clk) disable iff (!rstn)
         ce && hit_b && cnt_b_q < 32'hFFFFFFFF
         |=> cnt_b_q == $past(cnt_b_q) + 32'h00000001;
   endproperty
   a_cnt_b: assert property (p_cnt_b) else $error("counter b missed");

   property p_cnt_a_res;
      @(posedge clk) disable iff (!rstn)
         ce && dl_event_valid && !code_ok
         |=> cnt_a_q == $past(cnt_a_q);
   endproperty
   a_cnt_a_res: assert property (p_cnt_a_res) else $error("reserved code counted");

   // each event bit must land in its own flag one cycle later
   property p_ext_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_EXT_MSG]
         |=> flags_q[F_EXT_MSG];
   endproperty
   a_ext_set: assert property (p_ext_set) else $error("extracted flag not set");

   property p_io_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_RX_IO]
         |=> flags_q[F_RX_IO];
   endproperty
   a_io_set: assert property (p_io_set) else $error("io flag not set");

   property p_mem_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_RX_MEM]
         |=> flags_q[F_RX_MEM];
   endproperty
   a_mem_set: assert property (p_mem_set) else $error("memory flag not set");

   property p_cfg_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_RX_CFG]
         |=> flags_q[F_RX_CFG];
   endproperty
   a_cfg_set: assert property (p_cfg_set) else $error("config flag not set");

   property p_null_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_NULL]
         |=> flags_q[F_NULL];
   endproperty
   a_null_set: assert property (p_null_set) else $error("nullified flag not set");

   property p_malform_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_MALFORM]
         |=> flags_q[F_MALFORM];
   endproperty
   a_malform_set: assert property (p_malform_set) else $error("malformed flag not set");

   property p_ur_set;
      @(posedge clk) disable iff (!rstn)
         ce && tl_event[F_RX_UR]
         |=> flags_q[F_RX_UR];
   endproperty
   a_ur_set: assert property (p_ur_set) else $error("unsupported flag not set");

   // a zero written to a set flag must leave it alone
   property p_msg_w0;
      @(posedge clk) disable iff (!rstn)
         ce && flags_q[F_RX_MSG] && wr && hit_flg && !avs_writedata[F_RX_MSG]
         |=> flags_q[F_RX_MSG];
   endproperty
   a_msg_w0: assert property (p_msg_w0) else $error("zero write cleared flag");

   property p_tag_wrap_ext;
      @(posedge clk) disable iff (!rstn)
         ce && posted_tlp_gen && ctrl_q[C_POSTED_TAG_SEQUENCING] && ext_tag_en && tag_q == 8'hFF
         |=> posted_tag == 8'h00;
   endproperty
   a_tag_wrap_ext: assert property (p_tag_wrap_ext) else $error("long tag wrap");

   property p_tag_hold;
      @(posedge clk) disable iff (!rstn)
         ce && ctrl_q[C_POSTED_TAG_SEQUENCING] && !posted_tlp_gen
         |=> $stable(posted_tag);
   endproperty
   a_tag_hold: assert property (p_tag_hold) else $error("tag moved without a packet");

   property p_sel_hold;
      @(posedge clk) disable iff (!rstn)
         ce && !(wr && hit_sel)
         |=> $stable(sel_q);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("selector changed");

   property p_ctl_hold;
      @(posedge clk) disable iff (!rstn)
         ce && !(wr && hit_ctl)
         |=> $stable(ctrl_q);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold) else $error("control changed");

   // clock enable low must freeze every register
   property p_freeze;
      @(posedge clk) disable iff (!rstn)
         !ce
         |=> $stable(flags_q) && $stable(ctrl_q) && $stable(sel_q) && $stable(posted_tag);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   // mask may change in the same edge, so the old mask is the one that counts
   property p_irq_level;
      @(posedge clk) disable iff (!rstn)
         ce
         |=> irq == |(flags_q & $past(mask_q));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

   property p_rvalid;
      @(posedge clk) disable iff (!rstn)
         ce && rd
         |=> avs_readdatavalid;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("no read data valid");

   sequence s_req;
      ce && (avs_read || avs_write) && avs_waitrequest && bus_q == PLESC_IDLE;
   endsequence
   sequence s_ack;
      ce && !avs_waitrequest;
   endsequence
   property p_bus_ack;
      @(posedge clk) disable iff (!rstn)
         s_req |=> !avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("no bus answer");

   // the answer lasts one cycle; a request still held in the next idle cycle is taken again
   property p_wait_one;
      @(posedge clk) disable iff (!rstn)
         s_ack |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
endmodule

// [plesc_link_partner.sv]
`timescale 1ns/1ps
module plesc_link_partner (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [31:0] req_tl,
   input  wire logic        req_dv,
   input  wire logic [4:0]  req_code,
   input  wire logic        req_post,
   output logic [31:0]      tl_event,
   output logic             dl_event_valid,
   output logic [4:0]       dl_event_code,
   output logic             posted_tlp_gen
);
   // one cycle of link latency; idle code line toggles to its inverse each cycle while valid stays low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tl_event <= '0;
         dl_event_valid <= 1'b0;
         dl_event_code <= '0;
         posted_tlp_gen <= 1'b0;
      end else begin
         tl_event <= req_tl;
         dl_event_valid <= req_dv;
         dl_event_code <= req_dv ? req_code : ~dl_event_code;
         posted_tlp_gen <= req_post;
      end
   end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import plesc_pkg::*;
   logic        clk = 0, rstn = 0, ce = 1, rd = 0, wr = 0, ext = 0;
   logic        q_dv = 0, q_post = 0, irq, dv, post, fcp, wreq, rdv;
   logic [4:0]  q_code = '0, code;
   logic [3:0]  be = 4'hF;
   logic [11:0] addr = '0;
   logic [31:0] wd = '0, rdat, q_tl = '0, tl, seed = 32'h217F;
   logic [7:0]  tag;
   int          miscompares = 0, cmp_count = 0, p, n;
   initial forever #50 clk = ~clk;
   plesc_regs plesc_regs_inst (.clk(clk), .rstn(rstn), .ce(ce), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .avs_readdatavalid(rdv),
      .tl_event(tl), .dl_event_valid(dv), .dl_event_code(code), .posted_tlp_gen(post),
      .ext_tag_en(ext), .posted_tag(tag), .fc_update_pulse(fcp), .irq(irq));
   plesc_link_partner plesc_link_partner_inst (.clk(clk), .rstn(rstn), .req_tl(q_tl),
      .req_dv(q_dv), .req_code(q_code), .req_post(q_post), .tl_event(tl),
      .dl_event_valid(dv), .dl_event_code(code), .posted_tlp_gen(post));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [31:0] exp_tag(input int k, input logic e);
      return e ? k % 256 : k % 32;
   endfunction
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int k;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wd <= d;
      k = 0;
      do begin @(posedge clk); k++; end while (wreq !== 1'b0 && k < 50);
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 50) miscompares++;
   endtask
   task automatic wrr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      check(r, e);
   endtask
   task automatic ev(input logic [31:0] m);
      @(posedge clk);
      q_tl <= m;
      @(posedge clk);
      q_tl <= '0;
      repeat (3) @(posedge clk);
   endtask
   task automatic pulses(input int k, input logic d, input logic [4:0] c);
      @(posedge clk);
      q_post <= !d;
      q_dv <= d;
      q_code <= c;
      repeat (k) @(posedge clk);
      q_post <= 1'b0;
      q_dv <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic fc_period(output int q);
      int k;
      for (k = 0; k < 2; k++) begin
         q = 0;
         do begin @(posedge clk); q++; end while (fcp !== 1'b1 && q < 2000);
      end
   endtask
   initial begin
      #(100 * 30000);
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rdc(OFF_SELECT, RESET_ZERO);
      rdc(OFF_FLAGS, RESET_ZERO);
      rdc(OFF_CONTROL, RESET_ZERO);
      rdc(12'h7F0, RESET_ZERO);
      repeat (4) begin
         seed = xs(seed);
         wrr(OFF_SELECT, seed);
         rdc(OFF_SELECT, seed & SELECT_MASK);
         wrr(OFF_CONTROL, ~seed);
         rdc(OFF_CONTROL, ~seed & CONTROL_MASK);
      end
      wrr(OFF_IRQ_EN, FLAGS_MASK);
      for (int i = 0; i < 32; i++) if (FLAGS_MASK[i]) begin
         ev(32'h1 << i);
         check({31'h0, irq}, 32'h1);
         wrr(OFF_FLAGS, ~(32'h1 << i));
         rdc(OFF_FLAGS, 32'h1 << i);
         wrr(OFF_FLAGS, 32'h1 << i);
         rdc(OFF_FLAGS, RESET_ZERO);
         check({31'h0, irq}, 32'h0);
      end
      wrr(OFF_IRQ_EN, RESET_ZERO);
      ev(~FLAGS_MASK);
      rdc(OFF_FLAGS, RESET_ZERO);
      // event held across the clearing write must survive it
      q_tl <= 32'h1 << F_RX_MSG;
      wrr(OFF_FLAGS, 32'h1 << F_RX_MSG);
      q_tl <= '0;
      rdc(OFF_FLAGS, 32'h1 << F_RX_MSG);
      check({31'h0, irq}, 32'h0);
      ce <= 1'b0;
      ev(32'h1 << F_RX_IO);
      ce <= 1'b1;
      rdc(OFF_FLAGS, 32'h1 << F_RX_MSG);
      wrr(OFF_CONTROL, RESET_ZERO);
      pulses(5, 1'b0, 5'h0);
      check({24'h0, tag}, 32'h0);
      for (int e = 0; e < 2; e++) begin
         wrr(OFF_CONTROL, RESET_ZERO);
         ext <= e[0];
         seed = xs(seed);
         n = 250 + (seed % 20);
         wrr(OFF_CONTROL, 32'h1 << C_POSTED_TAG_SEQUENCING);
         pulses(n, 1'b0, 5'h0);
         check({24'h0, tag}, exp_tag(n, e[0]));
      end
      seed = xs(seed);
      foreach (seed[i]) if (i < 3) begin
         n = (i == 0) ? 0 : seed[5:0] + i;
         wrr(OFF_CONTROL, (32'h1 << C_FC_OVR) | n);
         fc_period(p);
         check(32'(p), n + 1);
      end
      wrr(OFF_CONTROL, 32'h5);
      fc_period(p);
      check(32'(p), FC_DEFAULT_INTERVAL + 1);
      wrr(OFF_SELECT, 32'h0704);
      pulses(3, 1'b1, 5'h4);
      pulses(2, 1'b1, 5'h7);
      pulses(1, 1'b1, 5'h1);
      rdc(OFF_EVCNT_A, 32'h3);
      rdc(OFF_EVCNT_B, 32'h0);
      print_verdict();
   end
endmodule
